// [shared/and_bit_ops_pkg.sv]
// Constants and types for the AND and single-bit execution block.
// Assumes a 12-bit instruction word and an 8-bit data path.
//
// Behaviour
// (RULE1) The register AND forms accumulator AND addressed register as its result.
// (RULE2) Register AND writes the accumulator when dest bit is 0, the register when 1.
// (RULE3) Bit operations take a 5-bit register index (0-31) and a 3-bit position (0-7).
// (RULE4) Bit clear forces the chosen bit to 0, keeps the rest and leaves flags alone.
// (RULE5) Bit set forces the chosen bit to 1, keeps the rest and leaves flags alone.
// (RULE6) Literal AND writes accumulator AND literal to the accumulator; both ANDs set Z.
package and_bit_ops_pkg;

    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int REG_IDX_W = 5;
    localparam int BIT_POS_W = 3;

    // ------------------------------------------------------------------
    // Instruction field positions
    // ------------------------------------------------------------------
    localparam int REG_IDX_LSB = 0;
    localparam int DEST_SEL_POS = 5;
    localparam int BIT_POS_LSB = 5;
    localparam int IMM_LSB = 0;

    // ------------------------------------------------------------------
    // Opcode patterns and masks
    // ------------------------------------------------------------------
    localparam logic [11:0] OPC_MASK_REG_AND = 12'hFC0;
    localparam logic [11:0] OPC_REG_AND = 12'h140;
    localparam logic [11:0] OPC_MASK_BIT = 12'hF00;
    localparam logic [11:0] OPC_BIT_CLEAR = 12'h400;
    localparam logic [11:0] OPC_BIT_SET = 12'h500;
    localparam logic [11:0] OPC_IMM_AND = 12'hE00;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [4:0] IDX_RST = 5'h00;

    typedef enum logic [4:0] {
        OP_NONE = 5'b00001,
        OP_REG_AND = 5'b00010,
        OP_IMM_AND = 5'b00100,
        OP_BIT_CLEAR = 5'b01000,
        OP_BIT_SET = 5'b10000
    } exec_op_t;

endpackage

// [tb/and_bit_ops_exec_test.sv]
// Self-checking bench for the AND and single-bit execution block.
// Assumes the register file model answers reads in the same cycle.
`timescale 1ns/1ps
module and_bit_ops_exec_test;
    import and_bit_ops_pkg::*;
    logic sys_clk_i;
    logic srst_i;
    logic [INSN_W-1:0] insn_i;
    logic insn_valid_i;
    logic [REG_IDX_W-1:0] reg_raddr_o;
    logic [REG_IDX_W-1:0] reg_waddr_o;
    logic [DATA_W-1:0] reg_rdata_i;
    logic [DATA_W-1:0] reg_wdata_o;
    logic [DATA_W-1:0] accum_o;
    logic reg_we_o;
    logic zero_we_o;
    logic zero_o;
    logic accum_load_i;
    logic [DATA_W-1:0] accum_load_data_i;
    logic [7:0] shadow [0:31];
    int num_errors;
    int samples_checked;

    and_bit_ops_exec dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .insn_i(insn_i),
        .insn_valid_i(insn_valid_i), .reg_raddr_o(reg_raddr_o), .reg_rdata_i(reg_rdata_i),
        .reg_we_o(reg_we_o), .reg_waddr_o(reg_waddr_o), .reg_wdata_o(reg_wdata_o),
        .accum_load_i(accum_load_i), .accum_load_data_i(accum_load_data_i),
        .accum_o(accum_o), .zero_we_o(zero_we_o), .zero_o(zero_o));
    reg_file_model rf (.sys_clk_i(sys_clk_i), .raddr_i(reg_raddr_o), .rdata_o(reg_rdata_i),
        .we_i(reg_we_o), .waddr_i(reg_waddr_o), .wdata_i(reg_wdata_o));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // Drives one instruction and returns just after the edge that takes it.
    task automatic issue(input logic [11:0] insn, input logic valid);
        @(posedge sys_clk_i);
        insn_i <= insn;
        insn_valid_i <= valid;
        #1 chk("reg_raddr", 8'(insn[4:0]), 8'(reg_raddr_o));
        @(posedge sys_clk_i);
        insn_valid_i <= 1'b0;
        #1;
    endtask

    // Loads the accumulator through the core's load port and checks that it took.
    task automatic load_accum(input logic [7:0] value);
        @(posedge sys_clk_i);
        accum_load_i <= 1'b1;
        accum_load_data_i <= value;
        @(posedge sys_clk_i);
        accum_load_i <= 1'b0;
        #1 chk("accum_load", value, accum_o);
    endtask

    task automatic expect_out(input logic we, input logic [4:0] a, input logic [7:0] d,
        input logic zwe, input logic z, input logic [7:0] acc);
        chk("reg_we", 8'(we), 8'(reg_we_o));
        if (we)
        begin
            chk("reg_waddr", 8'(a), 8'(reg_waddr_o));
            chk("reg_wdata", d, reg_wdata_o);
        end
        chk("zero_we", 8'(zwe), 8'(zero_we_o));
        if (zwe)
            chk("zero", 8'(z), 8'(zero_o));
        chk("accum", acc, accum_o);
    endtask

    task automatic test_bit_ops();
        logic [4:0] f;
        logic [7:0] m;
        load_accum(8'hC3);
        for (int i = 0; i < 16; i++)
        begin
            f = (i < 8) ? 5'h00 : 5'h1F;
            m = 8'h01 << i[2:0];
            issue(OPC_BIT_CLEAR | {4'h0, i[2:0], f}, 1'b1);
            expect_out(1'b1, f, shadow[f] & ~m, 1'b0, 1'b0, 8'hC3);
            issue(OPC_BIT_SET | {4'h0, i[2:0], f}, 1'b1);
            expect_out(1'b1, f, shadow[f] | m, 1'b0, 1'b0, 8'hC3);
            shadow[f] = shadow[f] | m;
        end
    endtask

    task automatic test_and_ops();
        logic [4:0] f;
        logic [7:0] a;
        logic [7:0] r;
        load_accum(8'hA3);
        issue(OPC_IMM_AND | 12'h05F, 1'b1);
        expect_out(1'b0, 5'h00, 8'h00, 1'b1, 1'b0, 8'h03);
        issue(OPC_IMM_AND | 12'h0FC, 1'b1);
        expect_out(1'b0, 5'h00, 8'h00, 1'b1, 1'b1, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            f = i[1] ? 5'h1F : 5'h02;
            a = i[1] ? 8'h00 : 8'h96;
            r = a & shadow[f];
            load_accum(a);
            issue(OPC_REG_AND | {6'h00, i[0], f}, 1'b1);
            expect_out(i[0], f, r, 1'b1, r == 8'h00, i[0] ? a : r);
            if (i[0])
                shadow[f] = r;
        end
    endtask

    task automatic test_refused();
        load_accum(8'h5A);
        issue(12'h6E3, 1'b1);
        expect_out(1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 8'h5A);
        issue(12'h1C5, 1'b1);
        expect_out(1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 8'h5A);
        issue(OPC_BIT_SET | 12'h0E3, 1'b0);
        expect_out(1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 8'h5A);
        issue(OPC_IMM_AND, 1'b0);
        expect_out(1'b0, 5'h00, 8'h00, 1'b0, 1'b0, 8'h5A);
    endtask

    task automatic test_back_to_back();
        @(posedge sys_clk_i);
        insn_i <= OPC_BIT_SET | 12'h0E3;
        insn_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        insn_i <= OPC_BIT_CLEAR | 12'h004;
        #1 expect_out(1'b1, 5'h03, shadow[3] | 8'h80, 1'b0, 1'b0, 8'h5A);
        @(posedge sys_clk_i);
        insn_i <= OPC_IMM_AND | 12'h00F;
        #1 expect_out(1'b1, 5'h04, shadow[4] & 8'hFE, 1'b0, 1'b0, 8'h5A);
        @(posedge sys_clk_i);
        insn_i <= OPC_IMM_AND | 12'h0F0;
        #1 expect_out(1'b0, 5'h00, 8'h00, 1'b1, 1'b0, 8'h0A);
        @(posedge sys_clk_i);
        insn_valid_i <= 1'b0;
        #1 expect_out(1'b0, 5'h00, 8'h00, 1'b1, 1'b1, 8'h00);
    endtask

    // A reset in mid-run must drop a pending instruction and clear the accumulator.
    task automatic test_reset();
        load_accum(8'h7E);
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        insn_i <= OPC_BIT_SET | 12'h0E3;
        insn_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        srst_i <= 1'b0;
        insn_valid_i <= 1'b0;
        #1 expect_out(1'b0, 5'h00, 8'h00, 1'b0, 1'b0, ACCUM_RST);
    endtask

    task automatic close_out();
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        num_errors++;
        close_out();
    end

    initial
    begin
        srst_i = 1'b1;
        insn_i = '0;
        insn_valid_i = 1'b0;
        accum_load_i = 1'b0;
        accum_load_data_i = '0;
        num_errors = 0;
        samples_checked = 0;
        repeat (4) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        #1 expect_out(1'b0, 5'h00, 8'h00, 1'b0, 1'b0, ACCUM_RST);
        foreach (shadow[i])
            shadow[i] = rf.mem[i];
        test_bit_ops();
        test_and_ops();
        test_refused();
        test_back_to_back();
        test_reset();
        close_out();
    end
endmodule

// [tb/reg_file_model.sv]
// Behavioural data register file on the far side of the execution block.
// Assumes reads are combinational and writes land on the next rising edge.
`timescale 1ns/1ps
module reg_file_model
(
    // Clock
    input wire logic sys_clk_i,
    // Read side
    input wire logic [and_bit_ops_pkg::REG_IDX_W-1:0] raddr_i,
    output logic [and_bit_ops_pkg::DATA_W-1:0] rdata_o,
    // Write side
    input wire logic we_i,
    input wire logic [and_bit_ops_pkg::REG_IDX_W-1:0] waddr_i,
    input wire logic [and_bit_ops_pkg::DATA_W-1:0] wdata_i
);
    import and_bit_ops_pkg::*;
    logic [DATA_W-1:0] mem [0:31];
    initial
    begin
        for (int i = 0; i < 32; i++)
            mem[i] = 8'(i * 37 + 90);
    end
    assign rdata_o = mem[raddr_i];
    always @(posedge sys_clk_i)
    begin
        if (we_i)
            mem[waddr_i] <= wdata_i;
    end
endmodule

// [verilog/and_bit_ops_exec.sv]
// Execution of register AND, literal AND, bit clear and bit set.
// Assumes the register file presents the addressed register on reg_rdata_i
// in the same cycle as the instruction, indexed by reg_raddr_o.
`timescale 1ns/1ps
module and_bit_ops_exec
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Instruction
    input wire logic [and_bit_ops_pkg::INSN_W-1:0] insn_i,
    input wire logic insn_valid_i,
    // Register file read
    output logic [and_bit_ops_pkg::REG_IDX_W-1:0] reg_raddr_o,
    input wire logic [and_bit_ops_pkg::DATA_W-1:0] reg_rdata_i,
    // Register file write
    output logic reg_we_o,
    output logic [and_bit_ops_pkg::REG_IDX_W-1:0] reg_waddr_o,
    output logic [and_bit_ops_pkg::DATA_W-1:0] reg_wdata_o,
    // Accumulator load from the rest of the core
    input wire logic accum_load_i,
    input wire logic [and_bit_ops_pkg::DATA_W-1:0] accum_load_data_i,
    // Accumulator and zero flag
    output logic [and_bit_ops_pkg::DATA_W-1:0] accum_o,
    output logic zero_we_o,
    output logic zero_o
);
    import and_bit_ops_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_POS_W-1:0] pos);
        bit_mask = 8'h01 << pos;
    endfunction

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    exec_op_t op;
    logic [REG_IDX_W-1:0] reg_idx;
    logic [BIT_POS_W-1:0] bit_pos;
    logic dest_sel;
    logic [DATA_W-1:0] imm;

    insn_field_decode u_decode
    (
        .insn_i(insn_i),
        .insn_valid_i(insn_valid_i),
        .op_o(op),
        .reg_idx_o(reg_idx),
        .bit_pos_o(bit_pos),
        .dest_sel_o(dest_sel),
        .imm_o(imm)
    );

    // The read address is combinational so the register file answers in-cycle.
    assign reg_raddr_o = reg_idx;

    // ------------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] accum_reg, accum_next;
    logic reg_we_reg, reg_we_next;
    logic [REG_IDX_W-1:0] waddr_reg, waddr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic zero_we_reg, zero_we_next;
    logic zero_reg, zero_next;
    logic [DATA_W-1:0] and_result;

    always_comb
    begin
        accum_next = accum_reg;
        reg_we_next = 1'b0;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        zero_we_next = 1'b0;
        zero_next = zero_reg;
        and_result = 8'h00;
        // Other instructions of the core write the accumulator here; a literal AND or a register AND
        // to the accumulator in the same cycle overrides the load.
        if (accum_load_i)
        begin
            accum_next = accum_load_data_i;
        end
        case (op)
            OP_REG_AND:
            begin
                and_result = accum_reg & reg_rdata_i; // [RULE1]
                zero_we_next = 1'b1;
                zero_next = (and_result == 8'h00); // [RULE6]
                if (dest_sel)
                begin
                    reg_we_next = 1'b1; // [RULE2]
                    waddr_next = reg_idx;
                    wdata_next = and_result;
                end
                else
                begin
                    accum_next = and_result; // [RULE2]
                end
            end
            OP_IMM_AND:
            begin
                and_result = accum_reg & imm; // [RULE6]
                accum_next = and_result;
                zero_we_next = 1'b1;
                zero_next = (and_result == 8'h00); // [RULE6]
            end
            OP_BIT_CLEAR:
            begin
                reg_we_next = 1'b1;
                waddr_next = reg_idx;
                wdata_next = reg_rdata_i & ~bit_mask(bit_pos); // [RULE4]
            end
            OP_BIT_SET:
            begin
                reg_we_next = 1'b1;
                waddr_next = reg_idx;
                wdata_next = reg_rdata_i | bit_mask(bit_pos); // [RULE5]
            end
            OP_NONE:
            begin
                reg_we_next = 1'b0;
            end
            default:
            begin
                reg_we_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            accum_reg <= ACCUM_RST;
            reg_we_reg <= 1'b0;
            waddr_reg <= IDX_RST;
            wdata_reg <= RESULT_RST;
            zero_we_reg <= 1'b0;
            zero_reg <= 1'b0;
        end
        else
        begin
            accum_reg <= accum_next;
            reg_we_reg <= reg_we_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            zero_we_reg <= zero_we_next;
            zero_reg <= zero_next;
        end
    end

    assign accum_o = accum_reg;
    assign reg_we_o = reg_we_reg;
    assign reg_waddr_o = waddr_reg;
    assign reg_wdata_o = wdata_reg;
    assign zero_we_o = zero_we_reg;
    assign zero_o = zero_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_reg_and_value: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE1]
        (op == OP_REG_AND && !dest_sel) |=> accum_o == ($past(accum_o) & $past(reg_rdata_i)))
        else $error("register AND result wrong");

    a_and_dest_reg: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE2]
        (op == OP_REG_AND && dest_sel && !accum_load_i) |=> reg_we_o
        && reg_waddr_o == $past(reg_idx) && accum_o == $past(accum_o)
        && reg_wdata_o == ($past(accum_o) & $past(reg_rdata_i)))
        else $error("register AND destination wrong");

    a_and_dest_acc: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE2]
        (op == OP_REG_AND && !dest_sel) |=> !reg_we_o)
        else $error("register AND wrote the register");

    a_field_index: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE3]
        (op == OP_BIT_SET) |=> reg_waddr_o == $past(insn_i[4:0]))
        else $error("bit op register index wrong");

    a_bit_clear_op: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE4]
        (op == OP_BIT_CLEAR) |=> reg_we_o && !zero_we_o
        && reg_wdata_o == ($past(reg_rdata_i) & ~(8'h01 << $past(insn_i[7:5]))))
        else $error("bit clear result wrong");

    a_bit_set_op: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE5]
        (op == OP_BIT_SET) |=> reg_we_o && !zero_we_o
        && reg_wdata_o == ($past(reg_rdata_i) | (8'h01 << $past(insn_i[7:5]))))
        else $error("bit set result wrong");

    a_imm_and_value: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE6]
        (op == OP_IMM_AND) |=> accum_o == ($past(accum_o) & $past(insn_i[7:0])) && !reg_we_o)
        else $error("literal AND result wrong");

    a_zero_flag_and: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE6]
        (op == OP_REG_AND) |=> zero_we_o
        && zero_o == (($past(accum_o) & $past(reg_rdata_i)) == 8'h00))
        else $error("register AND zero flag wrong");

    a_zero_flag_imm: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RULE6]
        (op == OP_IMM_AND) |=> zero_we_o
        && zero_o == (($past(accum_o) & $past(insn_i[7:0])) == 8'h00))
        else $error("literal AND zero flag wrong");

    a_accum_load: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (accum_load_i && op == OP_NONE) |=> accum_o == $past(accum_load_data_i))
        else $error("accumulator load lost");

    c_reg_and_to_reg: cover property (@(posedge sys_clk_i) op == OP_REG_AND && dest_sel);
    c_imm_and_zero: cover property (@(posedge sys_clk_i) op == OP_IMM_AND ##1 zero_o);
    c_bit_clear: cover property (@(posedge sys_clk_i) op == OP_BIT_CLEAR);
    c_bit_set_high: cover property (@(posedge sys_clk_i) op == OP_BIT_SET && bit_pos == 3'h7);

endmodule

// [verilog/insn_field_decode.sv]
// Opcode and field decoder for the AND and single-bit instructions.
// Assumes the instruction word is stable while valid is high.
`timescale 1ns/1ps
module insn_field_decode
(
    // Instruction in
    input wire logic [and_bit_ops_pkg::INSN_W-1:0] insn_i,
    input wire logic insn_valid_i,
    // Decoded fields
    output and_bit_ops_pkg::exec_op_t op_o,
    output logic [and_bit_ops_pkg::REG_IDX_W-1:0] reg_idx_o,
    output logic [and_bit_ops_pkg::BIT_POS_W-1:0] bit_pos_o,
    output logic dest_sel_o,
    output logic [and_bit_ops_pkg::DATA_W-1:0] imm_o
);
    import and_bit_ops_pkg::*;

    always_comb
    begin
        reg_idx_o = insn_i[REG_IDX_LSB +: REG_IDX_W]; // [RULE3]
        bit_pos_o = insn_i[BIT_POS_LSB +: BIT_POS_W]; // [RULE3]
        dest_sel_o = insn_i[DEST_SEL_POS];
        imm_o = insn_i[IMM_LSB +: DATA_W];
        op_o = OP_NONE;
        if (insn_valid_i)
        begin
            if ((insn_i & OPC_MASK_REG_AND) == OPC_REG_AND)
            begin
                op_o = OP_REG_AND;
            end
            else if ((insn_i & OPC_MASK_BIT) == OPC_BIT_CLEAR)
            begin
                op_o = OP_BIT_CLEAR;
            end
            else if ((insn_i & OPC_MASK_BIT) == OPC_BIT_SET)
            begin
                op_o = OP_BIT_SET;
            end
            else if ((insn_i & OPC_MASK_BIT) == OPC_IMM_AND)
            begin
                op_o = OP_IMM_AND;
            end
        end
    end

endmodule
